// *** core/uart_cfg.svh ***
// constants for the multidrop uart: timing counts, sample points, reset values
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define UART_DIV_W       12
`define UART_OVERSAMPLE  16
`define UART_SUB_W       4
`define UART_SAMPLE_A    8
`define UART_SAMPLE_B    9
`define UART_SAMPLE_C    10
`define UART_FRAME_8     10
`define UART_FRAME_9     11
`define UART_FIFO_DEPTH  8
`define UART_TX_BUFFER_EMPTY_RESET  1'H1
`define UART_LINE_IDLE   1'H1
`endif

// *** core/uart_pkg.sv ***
// types shared by the multidrop uart
`include "uart_cfg.svh"
package uart_pkg;
    typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;

    typedef struct packed {
        logic [`UART_DIV_W-1:0] div_cnt;
        logic [`UART_SUB_W-1:0] tx_sub;
        logic                   tx_active;
        logic [3:0]             tx_bits;
        logic [10:0]            tx_sh;
        logic                   tx_line;
        logic                   hold_full;
        logic [7:0]             hold_data;
        logic                   tx_buffer_empty;
        logic                   tx_complete_flag;
        rx_state_t              rx_state;
        logic [`UART_SUB_W-1:0] rx_samp;
        logic [3:0]             rx_bit;
        logic [1:0]             rx_votes;
        logic [8:0]             rx_sh;
        logic [7:0]             rx_data;
        logic                   rx_ninth;
        logic                   rx_complete_flag;
        logic                   fe;
        logic                   ovr;
        logic                   ovr_pend;
        logic                   tx_pin;
        logic                   tx_oe_n;
        logic                   rx_pin;
        logic                   rx_oe_n;
        logic                   rx_pu;
        logic                   irq_rx;
        logic                   irq_tx;
        logic                   irq_tx_buffer_empty;
    } uart_state_t;
endpackage : uart_pkg

// *** core/uart_tx_fifo.sv ***
// write-side fifo in front of the transmit holding register
`timescale 1ns/1ns
`include "uart_cfg.svh"
module uart_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `UART_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } fifo_state_t;

    fifo_state_t            st_reg;
    fifo_state_t            st_next;
    logic       [WIDTH-1:0] mem [DEPTH];
    logic                   push;
    logic                   pop;

    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign in_ready_out  = st_reg.count != (AW+1)'(DEPTH);
    assign out_valid_out = st_reg.count != '0;
    assign out_data_out  = mem[st_reg.rd_ptr];

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'H1;
    endfunction : ptr_inc

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = ptr_inc(st_reg.wr_ptr);
        end
        if (pop) begin
            st_next.rd_ptr = ptr_inc(st_reg.rd_ptr);
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wr_ptr] <= in_data_in;
        end
    end
endmodule : uart_tx_fifo

// *** core/uart_multidrop.sv ***
// full-duplex uart with nine-bit characters and multidrop address filtering
// Behaviour
// - idle shifter loads a written character immediately
// - busy shifter loads only after stop bit
// - each load sets the buffer-empty flag
// - frame: start zero low, stop one high
// - ninth-bit control copied into frame bit nine
// - start bit on next tick, then lsb first
// - buffer-empty stays set until next write
// - complete flag after stop held one bit
// - enabled transmitter owns and drives transmit pin
// - receiver samples at sixteen times bit rate
// - start rejected if samples 8-10 mostly high
// - data bits taken by majority of 8-10
// - low stop majority sets framing error
// - character moves to data, sets complete, unless data unread or address-filtered
// - reads see receive data, writes transmit
// - received ninth bit stored with the character
// - unread data: drop new, flag overrun later
// - enabled receiver forces pin input, pull-up kept
// - marker is stop bit, or ninth bit
// - address mode drops data bytes entirely
// - bit rate is clock over 16(divisor+1)
// - complete flag cleared by vector or write-one
// - reading receive data clears receive-complete
// - buffer-empty flag set during reset
`timescale 1ns/1ns
`include "uart_cfg.svh"
module uart_multidrop #(
    parameter int FIFO_DEPTH = `UART_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_n_in,
    // data port: write side
    input  wire logic                   data_wr_valid_in,
    input  wire logic [7:0]             data_wr_value_in,
    output logic                        data_wr_ready_out,
    // data port: read side
    input  wire logic                   data_rd_in,
    output logic      [7:0]             rx_data_out,
    // control
    input  wire logic                   transmitter_enable_in,
    input  wire logic                   receiver_enable_in,
    input  wire logic                   nine_bit_select_in,
    input  wire logic                   tx_ninth_bit_in,
    input  wire logic                   multidrop_address_mode_in,
    input  wire logic [`UART_DIV_W-1:0] baud_divisor_in,
    input  wire logic                   rx_complete_ie_in,
    input  wire logic                   tx_complete_ie_in,
    input  wire logic                   tx_empty_ie_in,
    input  wire logic                   tx_complete_clear_in,
    input  wire logic                   tx_complete_ack_in,
    // status
    output logic                        tx_buffer_empty_out,
    output logic                        tx_complete_flag_out,
    output logic                        rx_complete_flag_out,
    output logic                        framing_error_out,
    output logic                        overrun_out,
    output logic                        rx_ninth_bit_out,
    output logic                        irq_rx_complete_out,
    output logic                        irq_tx_complete_out,
    output logic                        irq_tx_empty_out,
    // transmit pin and its port settings
    input  wire logic                   tx_pin_direction_bit_in,
    input  wire logic                   tx_pin_port_bit_in,
    output logic                        transmit_port_pin_out,
    output logic                        transmit_port_pin_oe_n_out,
    // receive pin and its port settings
    input  wire logic                   receive_port_pin_in,
    input  wire logic                   rx_pin_direction_bit_in,
    input  wire logic                   rx_pin_pullup_bit_in,
    output logic                        receive_port_pin_out,
    output logic                        receive_port_pin_oe_n_out,
    output logic                        receive_port_pin_pullup_out
);
    uart_pkg::uart_state_t st_reg;
    uart_pkg::uart_state_t st_next;
    logic                  fifo_valid;
    logic                  fifo_ready;
    logic [7:0]            fifo_data;
    logic                  tick16;
    logic                  bit_tick;
    logic                  rx_vote;
    logic                  rx_done;
    logic                  rx_marker;
    logic                  rx_keep;
    logic [3:0]            rx_stop_idx;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    uart_tx_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (data_wr_valid_in),
        .in_data_in    (data_wr_value_in),
        .in_ready_out  (data_wr_ready_out),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_ready),
        .out_data_out  (fifo_data)
    );

    // the holding register drains the fifo only while empty
    assign fifo_ready  = !st_reg.hold_full && transmitter_enable_in;
    assign tick16      = st_reg.div_cnt == '0;
    assign bit_tick    = tick16 && (st_reg.tx_sub == `UART_SUB_W'(`UART_OVERSAMPLE - 1));
    assign rx_vote     = maj3(st_reg.rx_votes[1], st_reg.rx_votes[0], receive_port_pin_in);
    assign rx_stop_idx = nine_bit_select_in ? 4'(`UART_FRAME_9 - 1) : 4'(`UART_FRAME_8 - 1);
    assign rx_done     = tick16 && st_reg.rx_state == uart_pkg::RX_FRAME
                         && st_reg.rx_samp == `UART_SUB_W'(`UART_SAMPLE_C - 1)
                         && st_reg.rx_bit == rx_stop_idx;
    // stop bit or ninth bit marks an address byte
    assign rx_marker   = nine_bit_select_in ? st_reg.rx_sh[8] : rx_vote;
    assign rx_keep     = !multidrop_address_mode_in || rx_marker;

    always_comb begin
        st_next = st_reg;

        // baud divider: one tick per sixteenth of a bit
        st_next.div_cnt = tick16 ? baud_divisor_in : st_reg.div_cnt - 1'H1;
        if (tick16) begin
            st_next.tx_sub = st_reg.tx_sub + 1'H1;
        end

        // transmit shifter
        if (st_reg.tx_active && bit_tick) begin
            if (st_reg.tx_bits != '0) begin
                st_next.tx_line = st_reg.tx_sh[0];
                st_next.tx_sh   = {`UART_LINE_IDLE, st_reg.tx_sh[10:1]};
                st_next.tx_bits = st_reg.tx_bits - 1'H1;
            end else begin
                // stop bit has now stood a full bit time
                st_next.tx_active = 1'H0;
                if (!st_reg.hold_full) begin
                    st_next.tx_complete_flag = 1'H1;
                end
            end
        end
        if (!st_next.tx_active && st_reg.hold_full) begin
            st_next.tx_active = 1'H1;
            st_next.hold_full = 1'H0;
            st_next.tx_buffer_empty      = 1'H1;
            if (nine_bit_select_in) begin
                st_next.tx_sh   = {1'H1, tx_ninth_bit_in, st_reg.hold_data, 1'H0};
                st_next.tx_bits = 4'(`UART_FRAME_9);
            end else begin
                st_next.tx_sh   = {2'H3, st_reg.hold_data, 1'H0};
                st_next.tx_bits = 4'(`UART_FRAME_8);
            end
        end
        if (fifo_valid && fifo_ready) begin
            st_next.hold_full = 1'H1;
            st_next.hold_data = fifo_data;
            st_next.tx_buffer_empty      = 1'H0;
        end

        // complete flag: a new set wins over a clear in the same cycle
        if ((tx_complete_clear_in || tx_complete_ack_in)
            && !(st_reg.tx_active && bit_tick && st_reg.tx_bits == '0 && !st_reg.hold_full)) begin
            st_next.tx_complete_flag = 1'H0;
        end

        // receiver front end, ticks at sixteen per bit
        if (!receiver_enable_in) begin
            st_next.rx_state = uart_pkg::RX_IDLE;
        end else if (tick16) begin
            case (st_reg.rx_state)
                uart_pkg::RX_IDLE: begin
                    if (!receive_port_pin_in) begin
                        st_next.rx_state = uart_pkg::RX_FRAME;
                        st_next.rx_samp  = '0;
                        st_next.rx_bit   = '0;
                    end
                end
                uart_pkg::RX_FRAME: begin
                    st_next.rx_samp = st_reg.rx_samp + 1'H1;
                    if (st_reg.rx_samp == `UART_SUB_W'(`UART_OVERSAMPLE - 1)) begin
                        st_next.rx_bit = st_reg.rx_bit + 1'H1;
                    end
                    if (st_reg.rx_samp == `UART_SUB_W'(`UART_SAMPLE_A - 1)
                        || st_reg.rx_samp == `UART_SUB_W'(`UART_SAMPLE_B - 1)) begin
                        st_next.rx_votes = {st_reg.rx_votes[0], receive_port_pin_in};
                    end
                    if (st_reg.rx_samp == `UART_SUB_W'(`UART_SAMPLE_C - 1)) begin
                        if (st_reg.rx_bit == '0) begin
                            if (rx_vote) begin
                                st_next.rx_state = uart_pkg::RX_IDLE;
                            end
                        end else if (st_reg.rx_bit == rx_stop_idx) begin
                            st_next.rx_state = uart_pkg::RX_IDLE;
                        end else begin
                            st_next.rx_sh[4'(st_reg.rx_bit - 1'H1)] = rx_vote;
                        end
                    end
                end
                default: st_next.rx_state = uart_pkg::RX_IDLE;
            endcase
        end

        // reading the data register
        if (data_rd_in) begin
            st_next.rx_complete_flag      = 1'H0;
            st_next.ovr      = st_reg.ovr_pend;
            st_next.ovr_pend = 1'H0;
        end

        // end of character, stop sampled
        if (rx_done && receiver_enable_in && rx_keep) begin
            if (st_reg.rx_complete_flag && !data_rd_in) begin
                st_next.ovr_pend = 1'H1;
            end else begin
                st_next.rx_data = st_reg.rx_sh[7:0];
                st_next.rx_complete_flag     = 1'H1;
                st_next.fe      = !rx_vote;
                st_next.ovr     = 1'H0;
                if (nine_bit_select_in) begin
                    st_next.rx_ninth = st_reg.rx_sh[8];
                end
            end
        end

        // pin ownership; a pending character keeps the transmitter on the pin
        if (transmitter_enable_in || st_reg.tx_active || st_reg.hold_full) begin
            st_next.tx_pin  = st_next.tx_line;
            st_next.tx_oe_n = 1'H0;
        end else begin
            st_next.tx_pin  = tx_pin_port_bit_in;
            st_next.tx_oe_n = !tx_pin_direction_bit_in;
        end
        if (receiver_enable_in) begin
            st_next.rx_pin  = rx_pin_pullup_bit_in;
            st_next.rx_oe_n = 1'H1;
            st_next.rx_pu   = rx_pin_pullup_bit_in;
        end else begin
            st_next.rx_pin  = rx_pin_pullup_bit_in;
            st_next.rx_oe_n = !rx_pin_direction_bit_in;
            st_next.rx_pu   = rx_pin_pullup_bit_in && !rx_pin_direction_bit_in;
        end

        st_next.irq_rx   = st_next.rx_complete_flag && rx_complete_ie_in;
        st_next.irq_tx   = st_next.tx_complete_flag && tx_complete_ie_in;
        st_next.irq_tx_buffer_empty = st_next.tx_buffer_empty && tx_empty_ie_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_reg          <= '0;
            st_reg.tx_buffer_empty     <= `UART_TX_BUFFER_EMPTY_RESET;
            st_reg.tx_line  <= `UART_LINE_IDLE;
            st_reg.tx_pin   <= `UART_LINE_IDLE;
            st_reg.tx_oe_n  <= 1'H1;
            st_reg.rx_oe_n  <= 1'H1;
            st_reg.rx_state <= uart_pkg::RX_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rx_data_out                 = st_reg.rx_data;
    assign tx_buffer_empty_out         = st_reg.tx_buffer_empty;
    assign tx_complete_flag_out        = st_reg.tx_complete_flag;
    assign rx_complete_flag_out        = st_reg.rx_complete_flag;
    assign framing_error_out           = st_reg.fe;
    assign overrun_out                 = st_reg.ovr;
    assign rx_ninth_bit_out            = st_reg.rx_ninth;
    assign irq_rx_complete_out         = st_reg.irq_rx;
    assign irq_tx_complete_out         = st_reg.irq_tx;
    assign irq_tx_empty_out            = st_reg.irq_tx_buffer_empty;
    assign transmit_port_pin_out       = st_reg.tx_pin;
    assign transmit_port_pin_oe_n_out  = st_reg.tx_oe_n;
    assign receive_port_pin_out        = st_reg.rx_pin;
    assign receive_port_pin_oe_n_out   = st_reg.rx_oe_n;
    assign receive_port_pin_pullup_out = st_reg.rx_pu;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_idle_with_hold;
        !st_reg.tx_active && st_reg.hold_full;
    endsequence
    sequence s_shifter_loaded;
        st_reg.tx_active && st_reg.tx_buffer_empty && !st_reg.hold_full;
    endsequence
    sequence s_start_rejected;
        tick16 && st_reg.rx_state == uart_pkg::RX_FRAME && st_reg.rx_bit == '0
        && st_reg.rx_samp == `UART_SUB_W'(`UART_SAMPLE_C - 1) && rx_vote && receiver_enable_in;
    endsequence

    a_hold_to_shifter: assert property (s_idle_with_hold |=> s_shifter_loaded)
        else $error("holding register not moved into idle shifter");
    a_start_bit_out: assert property (st_reg.tx_active && bit_tick
        && ((nine_bit_select_in && st_reg.tx_bits == 4'(`UART_FRAME_9))
        || (!nine_bit_select_in && st_reg.tx_bits == 4'(`UART_FRAME_8)))
        |=> !st_reg.tx_line)
        else $error("first bit after load is not a start bit");
    a_stop_bit_high: assert property (st_reg.tx_active && st_reg.tx_bits == '0 |-> st_reg.tx_line)
        else $error("stop bit not high");
    a_txc_after_stop: assert property (st_reg.tx_active && st_reg.tx_bits == '0 && bit_tick
        && !st_reg.hold_full |=> st_reg.tx_complete_flag && !st_reg.tx_active)
        else $error("transmit complete not set after stop bit");
    a_tx_pin_owned: assert property (transmitter_enable_in |=> !transmit_port_pin_oe_n_out)
        else $error("enabled transmitter does not drive its pin");
    a_rx_pin_input: assert property (receiver_enable_in |=> receive_port_pin_oe_n_out)
        else $error("enabled receiver pin not forced to input");
    a_false_start: assert property (s_start_rejected |=> st_reg.rx_state == uart_pkg::RX_IDLE)
        else $error("noise spike accepted as start bit");
    a_framing_error: assert property (rx_done && receiver_enable_in && rx_keep && !st_reg.rx_complete_flag
        |=> st_reg.rx_complete_flag && (st_reg.fe == !$past(rx_vote)))
        else $error("framing error does not follow stop bit");
    a_data_dropped: assert property (rx_done && multidrop_address_mode_in && !rx_marker
        |=> $stable(st_reg.rx_data) && $stable(st_reg.fe))
        else $error("data byte not ignored in address mode");
    a_read_clears: assert property (data_rd_in && !rx_done |=> !st_reg.rx_complete_flag)
        else $error("read did not clear receive complete");
endmodule : uart_multidrop

// *** sim/uart_far_end.sv ***
// far-end serial partner: frames into the receiver, captures frames from the transmitter
`timescale 1ns/1ns
module uart_far_end (
    // clock
    input  wire logic clk_sys_in,
    // serial lines
    input  wire logic line_in,
    output logic      line_out
);
    int bit_clks = 16;
    // idle level is high between frames
    initial line_out = 1'H1;
    // lsb first, each bit held one full bit time, then one idle bit
    task automatic send(input logic [10:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            line_out = frame[i];
            repeat (bit_clks) @(posedge clk_sys_in);
            #1;
        end
        line_out = 1'H1;
        repeat (bit_clks) @(posedge clk_sys_in);
        #1;
    endtask : send
    // short low pulse that a receiver must not take for a start bit
    task automatic glitch(input int k);
        line_out = 1'H0;
        repeat (k) @(posedge clk_sys_in);
        #1;
        line_out = 1'H1;
    endtask : glitch
    // sample at bit centres; tick phase of the sender is unknown
    task automatic recv(output logic [10:0] frame, input int n);
        frame = 11'H000;
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge clk_sys_in);
        for (int i = 0; i < n; i++) begin
            frame[i] = line_in;
            repeat (bit_clks) @(posedge clk_sys_in);
        end
    endtask : recv
endmodule : uart_far_end

// *** sim/uart_multidrop_tb_top.sv ***
// self-checking bench for the multidrop uart
`timescale 1ns/1ns
module uart_multidrop_tb_top;
    logic        clk_sys_in = 1'H0;
    logic        rst_n_in = 1'H0;
    logic        wr_valid = 1'H0, rd = 1'H0, tx_en = 1'H1, rx_en = 1'H1, nine = 1'H0, tx9 = 1'H0;
    logic        multidrop_address_mode = 1'H0, txc_clr = 1'H0, txc_ack = 1'H0, gp = 1'H1;
    logic [7:0]  wr_value = 8'H00;
    logic [11:0] div = 12'H000;
    logic        wr_ready, tx_buffer_empty, tx_complete_flag, rx_complete_flag, fe, ovr, rx9, irq_rx, irq_tx, irq_e;
    logic        tx_line, tx_oe_n, rx_line, rx_pin_o, rx_oe_n, rx_pu;
    logic [7:0]  rx_data;
    logic [10:0] f1, f2;
    int          err_total = 0, total_checks = 0, cycles = 0;

    uart_multidrop i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .data_wr_valid_in(wr_valid), .data_wr_value_in(wr_value), .data_wr_ready_out(wr_ready),
        .data_rd_in(rd), .rx_data_out(rx_data), .transmitter_enable_in(tx_en), .receiver_enable_in(rx_en),
        .nine_bit_select_in(nine), .tx_ninth_bit_in(tx9), .multidrop_address_mode_in(multidrop_address_mode),
        .baud_divisor_in(div), .rx_complete_ie_in(gp), .tx_complete_ie_in(gp), .tx_empty_ie_in(gp),
        .tx_complete_clear_in(txc_clr), .tx_complete_ack_in(txc_ack), .tx_buffer_empty_out(tx_buffer_empty),
        .tx_complete_flag_out(tx_complete_flag), .rx_complete_flag_out(rx_complete_flag), .framing_error_out(fe), .overrun_out(ovr),
        .rx_ninth_bit_out(rx9), .irq_rx_complete_out(irq_rx), .irq_tx_complete_out(irq_tx),
        .irq_tx_empty_out(irq_e), .tx_pin_direction_bit_in(gp), .tx_pin_port_bit_in(gp),
        .transmit_port_pin_out(tx_line), .transmit_port_pin_oe_n_out(tx_oe_n), .receive_port_pin_in(rx_line),
        .rx_pin_direction_bit_in(gp), .rx_pin_pullup_bit_in(gp), .receive_port_pin_out(rx_pin_o),
        .receive_port_pin_oe_n_out(rx_oe_n), .receive_port_pin_pullup_out(rx_pu));
    uart_far_end i_far (.clk_sys_in(clk_sys_in), .line_in(tx_line), .line_out(rx_line));

    initial forever #5 clk_sys_in = ~clk_sys_in;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // hang guard: whole run is a few thousand cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("ERROR at %0t: run did not finish", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc
    // request held until an edge sees ready high
    task automatic write(input logic [7:0] d);
        wr_value = d;
        wr_valid = 1'H1;
        while (wr_ready !== 1'H1) cyc(1);
        cyc(1);
        wr_valid = 1'H0;
    endtask : write
    task automatic read;
        rd = 1'H1;
        cyc(1);
        rd = 1'H0;
    endtask : read
    task automatic tx_frame(input logic [7:0] d, input int n, input logic [10:0] exp);
        fork
            write(d);
            i_far.recv(f1, n);
        join
        chk(f1, exp, "transmitted frame");
    endtask : tx_frame
    task automatic rx_check(input logic [10:0] fr, input int n, input logic [7:0] d, input logic c);
        i_far.send(fr, n);
        chk(rx_data, d, "receive data");
        chk(rx_complete_flag, c, "receive complete");
    endtask : rx_check

    initial begin
        cyc(16);
        rst_n_in = 1'H1;
        cyc(2);
        chk(tx_buffer_empty, 1'H1, "empty flag after reset");
        chk({tx_complete_flag, rx_complete_flag, fe, ovr}, 4'H0, "flags after reset");
        chk({tx_line, tx_oe_n, rx_oe_n, rx_pu, rx_pin_o}, 5'H17, "pin ownership");
        tx_frame(8'HA5, 10, {1'H0, 1'H1, 8'HA5, 1'H0});
        cyc(30);
        chk({tx_complete_flag, irq_tx, tx_buffer_empty, irq_e}, 4'HF, "complete and empty");
        txc_clr = 1'H1;
        cyc(1);
        txc_clr = 1'H0;
        cyc(1);
        chk(tx_complete_flag, 1'H0, "complete cleared by write-one");
        fork
            begin write(8'H01); cyc(1); write(8'HFE); end
            begin i_far.recv(f1, 10); i_far.recv(f2, 10); end
        join
        chk(f1, {1'H0, 1'H1, 8'H01, 1'H0}, "first of pair");
        chk(f2, {1'H0, 1'H1, 8'HFE, 1'H0}, "second of pair");
        // slower divisor doubles the bit time
        nine = 1'H1;
        tx9 = 1'H1;
        div = 12'H001;
        i_far.bit_clks = 32;
        tx_frame(8'H5A, 11, {1'H1, 1'H1, 8'H5A, 1'H0});
        div = 12'H000;
        i_far.bit_clks = 16;
        cyc(60);
        chk(tx_complete_flag, 1'H1, "complete after nine-bit frame");
        txc_ack = 1'H1;
        cyc(1);
        txc_ack = 1'H0;
        cyc(1);
        chk(tx_complete_flag, 1'H0, "complete cleared by vector");
        nine = 1'H0;
        rx_check({1'H0, 1'H1, 8'H3C, 1'H0}, 10, 8'H3C, 1'H1);
        chk({fe, irq_rx}, 2'H1, "good stop and request");
        read();
        chk(rx_complete_flag, 1'H0, "read clears complete");
        rx_check({1'H0, 1'H0, 8'H81, 1'H0}, 10, 8'H81, 1'H1);
        chk(fe, 1'H1, "low stop");
        read();
        rx_check({1'H0, 1'H1, 8'H11, 1'H0}, 10, 8'H11, 1'H1);
        rx_check({1'H0, 1'H1, 8'H22, 1'H0}, 10, 8'H11, 1'H1);
        chk(ovr, 1'H0, "overrun held back");
        read();
        chk({ovr, rx_complete_flag}, 2'H2, "overrun after read");
        i_far.glitch(4);
        cyc(200);
        chk(rx_complete_flag, 1'H0, "noise spike rejected");
        multidrop_address_mode = 1'H1;
        rx_check({1'H0, 1'H0, 8'H77, 1'H0}, 10, 8'H11, 1'H0);
        chk(fe, 1'H0, "ignored byte leaves error");
        rx_check({1'H0, 1'H1, 8'H42, 1'H0}, 10, 8'H42, 1'H1);
        read();
        nine = 1'H1;
        rx_check({1'H1, 1'H0, 8'H99, 1'H0}, 11, 8'H42, 1'H0);
        rx_check({1'H1, 1'H1, 8'H07, 1'H0}, 11, 8'H07, 1'H1);
        chk(rx9, 1'H1, "received ninth bit");
        read();
        multidrop_address_mode = 1'H0;
        report_and_stop();
    end
endmodule : uart_multidrop_tb_top
